// File: rtl/bidirectional_counter_consts.svh
// Constants for the eight-digit up/down event counter
`ifndef BIDIRECTIONAL_COUNTER_CONSTS_SVH
`define BIDIRECTIONAL_COUNTER_CONSTS_SVH

`define BDC_DIGITS        8
`define BDC_WORD_W        16
`define BDC_VALUE_W       32
`define BDC_CNUM_W        9
`define BDC_ADDR_W        16
// Current-value block base, octal 1000 in word addressing
`define BDC_VALUE_BASE    16'h0200
`define BDC_HI_WORD_OFS   16'h0001
`define BDC_SLOTS_USED    9'h002
`define BDC_ZERO_VALUE    32'h0000_0000
`define BDC_MAX_VALUE     32'h9999_9999
`define BDC_DIGIT_ZERO    4'h0
`define BDC_DIGIT_NINE    4'h9
`define BDC_DIGIT_ONE     4'h1
`define BDC_PRESET_CONST  1'b0
`define BDC_PRESET_MEM    1'b1

`endif

// File: rtl/bidirectional_counter_pkg.sv
// Types shared by the up/down counter modules
package bidirectional_counter_pkg;
	typedef logic [31:0] bcd_value_t;
	typedef logic [15:0] mem_word_t;
	typedef logic [15:0] mem_addr_t;
	typedef logic [8:0]  counter_num_t;
	typedef enum logic [1:0] {
		STEP_HOLD = 2'b00,
		STEP_UP   = 2'b01,
		STEP_DOWN = 2'b11
	} step_t;
endpackage : bidirectional_counter_pkg

// File: rtl/bcd_step_if.sv
// Carrier between the counter control and its decimal stepper
`timescale 1ns/100ps
interface bcd_step_if;
	import bidirectional_counter_pkg::*;
	bcd_value_t value;
	step_t      step;
	bcd_value_t next_value;
	modport ctrl (output value, output step, input next_value);
	modport core (input value, input step, output next_value);
endinterface : bcd_step_if

// File: rtl/bcd_stepper.sv
// Combinational eight-digit decimal increment/decrement with saturation
`timescale 1ns/100ps
`include "bidirectional_counter_consts.svh"
module bcd_stepper #(
	parameter int DIGITS = `BDC_DIGITS
) (
	bcd_step_if.core step_if
);
	import bidirectional_counter_pkg::*;

	logic [DIGITS:0] all_nine;
	logic [DIGITS:0] all_zero;
	bcd_value_t      stepped;

	assign all_nine[0] = 1'b1;
	assign all_zero[0] = 1'b1;

	// Digit i moves only when every lower digit rolls over
	for (genvar i = 0; i < DIGITS; i++) begin : g_digit
		logic [3:0] d;
		logic [3:0] s;
		assign d = step_if.value[4*i +: 4];
		assign stepped[4*i +: 4] = s;
		assign all_nine[i+1] = all_nine[i] & (d == `BDC_DIGIT_NINE);
		assign all_zero[i+1] = all_zero[i] & (d == `BDC_DIGIT_ZERO);
		// One process per digit slice keeps a single driver on each bit
		always_comb begin
			s = d;
			if (step_if.step == STEP_UP && all_nine[i]) begin
				s = (d == `BDC_DIGIT_NINE) ? `BDC_DIGIT_ZERO
					: 4'(d + `BDC_DIGIT_ONE);
			end else if (step_if.step == STEP_DOWN && all_zero[i]) begin
				s = (d == `BDC_DIGIT_ZERO) ? `BDC_DIGIT_NINE
					: 4'(d - `BDC_DIGIT_ONE);
			end
		end
	end

	// Saturate instead of wrapping at either end of the range
	always_comb begin
		step_if.next_value = stepped;
		if (step_if.step == STEP_UP && all_nine[DIGITS]) begin
			step_if.next_value = step_if.value;
		end else if (step_if.step == STEP_DOWN && all_zero[DIGITS]) begin
			step_if.next_value = step_if.value;
		end
	end
endmodule : bcd_stepper

// File: rtl/bidirectional_counter.sv
// Eight-digit decimal up/down event counter with preset compare
// Behaviour
// - A rising edge on the up input adds one while the down input is off.
// - A rising edge on the down input subtracts one while the up input is off.
// - While the clear input is high the value is forced to zero above both count inputs.
// - The value spans zero to 99999999 as eight decimal digits.
// - The status output is high exactly when the value is at or above the preset.
// - The preset is an eight-digit constant or a double word of two 16-bit words.
// - The value is stored as two 16-bit words starting at counter number plus 1000.
// - One instance takes two counter slots, so the next free number is plus two.
// - On clear, the status output becomes preset-equals-zero in the same cycle the value goes to zero.
// - Comparisons against the value fall to not-met once the counter is cleared, except with a zero preset.
`timescale 1ns/100ps
`include "bidirectional_counter_consts.svh"
module bidirectional_counter #(
	parameter int DIGITS = `BDC_DIGITS
) (
	input  wire  logic                                   mclk_i,
	input  wire  logic                                   reset_n_i,
	input  wire  logic                                   count_up_i,
	input  wire  logic                                   count_down_i,
	input  wire  logic                                   clear_i,
	input  wire  logic                                   preset_src_i,
	input  wire  bidirectional_counter_pkg::bcd_value_t  preset_const_i,
	input  wire  bidirectional_counter_pkg::mem_word_t   preset_mem_lo_i,
	input  wire  bidirectional_counter_pkg::mem_word_t   preset_mem_hi_i,
	input  wire  bidirectional_counter_pkg::counter_num_t counter_number_i,
	output logic                                         status_o,
	output bidirectional_counter_pkg::bcd_value_t        value_o,
	output logic                                         value_we_o,
	output bidirectional_counter_pkg::mem_addr_t         value_addr_lo_o,
	output bidirectional_counter_pkg::mem_addr_t         value_addr_hi_o,
	output bidirectional_counter_pkg::mem_word_t         value_lo_o,
	output bidirectional_counter_pkg::mem_word_t         value_hi_o,
	output bidirectional_counter_pkg::counter_num_t      next_counter_o
);
	import bidirectional_counter_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Edge detection

	logic       up_prev_q;
	logic       down_prev_q;
	logic       up_edge;
	logic       down_edge;
	step_t      step;

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			up_prev_q   <= 1'b0;
			down_prev_q <= 1'b0;
		end else begin
			up_prev_q   <= count_up_i;
			down_prev_q <= count_down_i;
		end
	end

	assign up_edge   = count_up_i & ~up_prev_q;
	assign down_edge = count_down_i & ~down_prev_q;

	// Both inputs high means the program broke the one-input-at-a-time contract
	always_comb begin
		step = STEP_HOLD;
		if (up_edge && !count_down_i) begin
			step = STEP_UP;
		end else if (down_edge && !count_up_i) begin
			step = STEP_DOWN;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Count value

	bcd_step_if step_bus ();
	bcd_value_t value_q;
	bcd_value_t value_d;

	assign step_bus.value = value_q;
	assign step_bus.step  = step;

	bcd_stepper #(
		.DIGITS (DIGITS)
	) u_stepper (
		.step_if (step_bus)
	);

	always_comb begin
		value_d = step_bus.next_value;
		if (clear_i) begin
			value_d = `BDC_ZERO_VALUE;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			value_q <= `BDC_ZERO_VALUE;
		end else begin
			value_q <= value_d;
		end
	end

	assign value_o = value_q;

	////////////////////////////////////////////////////////////////////////////////
	// Preset compare

	bcd_value_t preset;
	logic       status_q;

	always_comb begin
		preset = preset_const_i;
		if (preset_src_i == `BDC_PRESET_MEM) begin
			preset = {preset_mem_hi_i, preset_mem_lo_i};
		end
	end

	// Packed decimal digits order the same as binary, so a plain compare works.
	// Compared against the next value so status and value change together.
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			status_q <= 1'b0;
		end else if (clear_i) begin
			status_q <= (preset == `BDC_ZERO_VALUE);
		end else begin
			status_q <= (value_d >= preset);
		end
	end

	assign status_o = status_q;

	////////////////////////////////////////////////////////////////////////////////
	// Double-word store of the value

	logic      we_q;
	mem_addr_t addr_lo_q;
	mem_addr_t addr_hi_q;
	counter_num_t next_num_q;

	// Address follows counter number by one cycle; store strobes only on a change
	always_ff @(posedge mclk_i) begin
		if (!reset_n_i) begin
			we_q       <= 1'b0;
			addr_lo_q  <= `BDC_VALUE_BASE;
			addr_hi_q  <= `BDC_VALUE_BASE + `BDC_HI_WORD_OFS;
			next_num_q <= `BDC_SLOTS_USED;
		end else begin
			we_q       <= (value_d != value_q);
			addr_lo_q  <= `BDC_VALUE_BASE + mem_addr_t'(counter_number_i);
			addr_hi_q  <= `BDC_VALUE_BASE + mem_addr_t'(counter_number_i)
				+ `BDC_HI_WORD_OFS;
			next_num_q <= counter_number_i + `BDC_SLOTS_USED;
		end
	end

	assign value_we_o      = we_q;
	assign value_addr_lo_o = addr_lo_q;
	assign value_addr_hi_o = addr_hi_q;
	assign value_lo_o      = value_q[15:0];
	assign value_hi_o      = value_q[31:16];
	assign next_counter_o  = next_num_q;
endmodule : bidirectional_counter

// File: dv/bidirectional_counter_sva.sv
// Port assertions for the up/down counter
`timescale 1ns/100ps
module bidirectional_counter_sva
	import bidirectional_counter_pkg::*;
#(
	parameter int DIGITS = 8
) (
	input wire logic         mclk_i,
	input wire logic         reset_n_i,
	input wire logic         count_up_i,
	input wire logic         count_down_i,
	input wire logic         clear_i,
	input wire logic         preset_src_i,
	input wire bcd_value_t   preset_const_i,
	input wire mem_word_t    preset_mem_lo_i,
	input wire mem_word_t    preset_mem_hi_i,
	input wire counter_num_t counter_number_i,
	input wire logic         status_o,
	input wire bcd_value_t   value_o,
	input wire mem_addr_t    value_addr_lo_o,
	input wire mem_addr_t    value_addr_hi_o,
	input wire counter_num_t next_counter_o
);
	localparam bcd_value_t TOP = 32'h9999_9999;
	logic       up_q;
	logic       dn_q;
	bcd_value_t psel;
	assign psel = preset_src_i ? {preset_mem_hi_i, preset_mem_lo_i} : preset_const_i;
	// Own edge samples, cleared by reset as the design's are
	always_ff @(posedge mclk_i) begin
		up_q <= reset_n_i & count_up_i;
		dn_q <= reset_n_i & count_down_i;
	end
	default clocking dc @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);
	sequence up_edge;
		!clear_i && count_up_i && !up_q && !count_down_i;
	endsequence
	sequence dn_edge;
		!clear_i && count_down_i && !dn_q && !count_up_i;
	endsequence
	a_clear_zeroes: assert property (clear_i |=> value_o == '0 && status_o == ($past(psel) == '0))
		else $error("clear failed");
	a_status_cmp: assert property (1'b1 |=> status_o == (value_o >= $past(psel)))
		else $error("status wrong");
	a_up_step: assert property (up_edge ##0 (value_o[3:0] < 4'h9) |=> value_o == $past(value_o) + 1)
		else $error("up step wrong");
	a_down_step: assert property (dn_edge ##0 (value_o[3:0] != 4'h0) |=> value_o == $past(value_o) - 1)
		else $error("down step wrong");
	a_both_hold: assert property (!clear_i && count_up_i && count_down_i |=> $stable(value_o))
		else $error("counted with both high");
	a_floor_hold: assert property (value_o == '0 && !(count_up_i && !up_q) |=> value_o == '0)
		else $error("wrapped below zero");
	a_top_hold: assert property (value_o == TOP && !clear_i && !(count_down_i && !dn_q) |=> value_o == TOP)
		else $error("wrapped above top");
	a_addr_slot: assert property (1'b1 |=> value_addr_lo_o == 16'h0200 + 16'($past(counter_number_i))
		&& value_addr_hi_o == value_addr_lo_o + 16'h0001 && next_counter_o == $past(counter_number_i) + 9'h002)
		else $error("address or slot wrong");
endmodule : bidirectional_counter_sva
bind bidirectional_counter bidirectional_counter_sva #(.DIGITS(DIGITS)) chk (.*);

// File: dv/count_program.sv
// Program-side driver of the two count inputs
`timescale 1ns/100ps
module count_program (
	input  wire logic [1:0] op_i,
	output logic            count_up_o,
	output logic            count_down_o
);
	// Unused input kept low; 2'b11 when a scenario commands the fault or a random step draws it
	assign count_up_o   = op_i[0];
	assign count_down_o = op_i[1];
endmodule : count_program

// File: dv/up_down_preset_counter_test.sv
// Self-checking bench for the up/down counter
`timescale 1ns/100ps
module up_down_preset_counter_test;
	import bidirectional_counter_pkg::*;
	logic mclk_i = 0, reset_n_i = 0, clear_i = 0, src = 0, cu, cd, status_o, value_we_o;
	logic [1:0]   op = 0;
	bcd_value_t   pc = 0, value_o;
	mem_word_t    plo = 0, phi = 0;
	mem_addr_t    alo, ahi;
	mem_word_t    vlo, vhi;
	logic [32:0]  want;
	counter_num_t num = 0, nxt;
	int           errors = 0, total_checks = 0, v = 0, p = 5;
	integer       seed = 32'h9ceeab38;
	logic [32:0]  q[$];
	count_program partner (.op_i(op), .count_up_o(cu), .count_down_o(cd));
	bidirectional_counter uut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .count_up_i(cu),
		.count_down_i(cd), .clear_i(clear_i), .preset_src_i(src), .preset_const_i(pc),
		.preset_mem_lo_i(plo), .preset_mem_hi_i(phi), .counter_number_i(num),
		.status_o(status_o), .value_o(value_o), .value_we_o(value_we_o),
		.value_addr_lo_o(alo), .value_addr_hi_o(ahi), .value_lo_o(vlo), .value_hi_o(vhi),
		.next_counter_o(nxt));
	function automatic bcd_value_t bcd(input int n);
		for (int i = 0; i < 8; i++) begin
			bcd[4*i+:4] = 4'(n % 10);
			n = n / 10;
		end
	endfunction : bcd
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic report_and_stop;
		if (errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : report_and_stop
	task automatic step(input logic [1:0] o);
		int w;
		w = v;
		op = o;
		if (o == 2'b01 && v < 99999999) v++;
		if (o == 2'b10 && v > 0) v--;
		if (v != w) q.push_back({v >= p, bcd(v)});
		@(posedge mclk_i) #2;
		op = 0;
		@(posedge mclk_i) #2;
	endtask : step
	task automatic zap;
		if (v != 0) q.push_back({p == 0, 32'h0});
		v = 0;
		clear_i = 1;
		op = 2'b01;
		@(posedge mclk_i) #2;
		clear_i = 0;
		op = 0;
		@(posedge mclk_i) #2;
	endtask : zap
	// Sampled mid-cycle, away from the register updates
	always @(negedge mclk_i) begin
		if (value_we_o === 1'b1) begin
			if (q.size() == 0) check(33'h0, 33'h1);
			else begin
				want = q.pop_front();
				check({status_o, value_o}, want);
				check({1'b0, vhi, vlo}, {1'b0, want[31:0]});
			end
		end
	end
	initial begin
		forever #12.5 mclk_i = ~mclk_i;
	end
	initial begin
		pc = bcd(p);
		repeat (20) @(posedge mclk_i);
		#2 reset_n_i = 1;
		num = 9'($random(seed));
		repeat (3) step(2'b10);
		repeat (8) step(2'b01);
		step(2'b11);
		zap;
		for (int i = 0; i < 300; i++) begin
			if (i == 150) begin
				p = {$random(seed)} % 20;
				{phi, plo} = bcd(p);
				src = 1;
			end
			if (i % 60 == 59) zap;
			step(2'($random(seed)));
		end
		check({1'b0, alo, ahi}, {1'b0, 16'h0200 + 16'(num), 16'h0201 + 16'(num)});
		check(33'(nxt), 33'(num + 9'h002));
		for (int i = 0; i < 10 && q.size() > 0; i++) @(posedge mclk_i);
		if (q.size() != 0) errors++;
		report_and_stop;
	end
endmodule : up_down_preset_counter_test
